// File: verilog/kmw_cfg.svh
// Register offsets, field positions, reset values and bus widths for the
// keyboard and mouse wake and isolation block.
// Assumes a byte-addressed classic Wishbone slave with 32-bit data.
`ifndef KMW_CFG_SVH
`define KMW_CFG_SVH

`define KMW_ADR_W           8
`define KMW_DAT_W           32

`define KMW_OFS_WAKE_STS    8'h10
`define KMW_OFS_WAKE_EN     8'h14
`define KMW_OFS_INT_STS     8'h18
`define KMW_OFS_INT_MASK    8'h1C
`define KMW_OFS_KBC_RST     8'h2C
`define KMW_OFS_CTL         8'hF0

`define KMW_BIT_GLOBAL_EN   0
`define KMW_BIT_KBD_WAKE    3
`define KMW_BIT_MOUSE_WAKE  4
`define KMW_BIT_KBD_LSEL    3
`define KMW_BIT_MOUSE_LSEL  4
`define KMW_BIT_KISO        5
`define KMW_BIT_MISO        6
`define KMW_BIT_KBC_RST     6

`define KMW_RST_BYTE        8'h00
`define KMW_KBC_RST_VALUE   8'h40
`define KMW_WAKE_MASK       8'h18
`define KMW_EN_MASK         8'h19
`define KMW_CTL_MASK        8'h78

`endif

// File: verilog/kmw_pkg.sv
// Types shared by the keyboard and mouse wake and isolation block.
// Assumes nothing beyond the configuration header for its widths.
package kmw_pkg;

  typedef struct packed {
    logic clock_line;
    logic data_line;
  } kmw_ps2_t;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } kmw_wb_req_t;

  typedef enum {
    KMW_BUS_IDLE,
    KMW_BUS_ACK
  } kmw_bus_state_t;

endpackage

// File: verilog/kmw_fall_sync.sv
// Two-stage synchroniser with a falling-edge pulse on its settled output.
// Assumes a single system clock and a synchronous active-high reset.
`timescale 1ns/1ps

module kmw_fall_sync (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic line_i,
  output logic      level_o,
  output logic      fall_o
);

  logic meta;
  logic settled;
  logic settled_d;

  // The idle level of an open-drain data line is high, so reset to high
  // keeps a line that is already idle from posing as an edge.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      meta      <= 1'b1;
      settled   <= 1'b1;
      settled_d <= 1'b1;
    end
    else
    begin
      meta      <= line_i;
      settled   <= meta;
      settled_d <= settled;
    end
  end

  assign level_o = settled;
  assign fall_o  = settled_d & ~settled; // see (RQ18)

endmodule

// File: verilog/kmw_wake_iso.sv
// Keyboard and mouse wake, interrupt latching and isolation block.
// Assumes a classic Wishbone master, rst_i as standby power-on reset and
// separate main-power and bus reset inputs that only touch main-well state.
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`include "kmw_cfg.svh"

// How it works
// (RQ1) Latch bits live in control register 0xF0.
// (RQ2) Mouse latch select picks gated or latched.
// (RQ3) Keyboard latch select picks gated or latched.
// (RQ4) Interrupts and data edges set wake status.
// (RQ5) Wake output needs own and global enable.
// (RQ6) Interrupt wakes need main power; edges don't.
// (RQ7) Mouse isolation blocks mouse lines to controller.
// (RQ8) Keyboard isolation blocks keyboard lines to controller.
// (RQ9) Isolation bits cleared only by standby reset.
// (RQ10) Writing 0x40 at global_cfg_controller_reset holds controller reset.
// (RQ11) Software resets controller after main-power sleep.
// (RQ12) Software sets only bit 6 at global_cfg_controller_reset.
// (RQ13) Data lines set wake status unisolated when low.
// (RQ14) Isolation stops only internal sources of wakes.
// (RQ15) Wake enables cleared only by standby reset.
// (RQ16) Boot software clears spurious wake status bits.
// (RQ17) Software clears enables before main-power sleep.
// (RQ18) Synchronised falling data edge is active edge.
module kmw_wake_iso (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  input  wire logic                 main_reset_i,
  input  wire logic                 bus_reset_i,
  input  wire logic                 main_power_good_i,
  input  wire kmw_pkg::kmw_wb_req_t wb_req_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  input  wire kmw_pkg::kmw_ps2_t    kbd_line_i,
  input  wire kmw_pkg::kmw_ps2_t    mouse_line_i,
  output kmw_pkg::kmw_ps2_t         kbc_kbd_line_o,
  output kmw_pkg::kmw_ps2_t         kbc_mouse_line_o,
  input  wire logic                 kbd_irq_i,
  input  wire logic                 mouse_irq_i,
  input  wire logic                 kbd_irq_clr_i,
  input  wire logic                 mouse_irq_clr_i,
  output logic                      kbd_irq_o,
  output logic                      mouse_irq_o,
  output logic                      kbc_reset_o,
  output logic                      wake_event_out_o,
  output logic                      irq_o
);

  logic [7:0] ctl_reg;
  logic [7:0] kbc_rst_reg;
  logic [7:0] wake_sts;
  logic [7:0] wake_en;
  logic [7:0] int_sts;
  logic [7:0] int_mask;
  logic       kbd_latch;
  logic       mouse_latch;
  logic       kbd_irq_src_d;
  logic       mouse_irq_src_d;
  kmw_pkg::kmw_bus_state_t bus_state;

  // Byte-lane write enable for the low byte of an aligned register.
  function automatic logic wr_hit(input kmw_pkg::kmw_wb_req_t req, input logic [7:0] ofs);
    wr_hit = req.cyc & req.stb & req.we & req.sel[0] & (req.adr == ofs);
  endfunction

  function automatic logic rd_hit(input kmw_pkg::kmw_wb_req_t req, input logic [7:0] ofs);
    rd_hit = req.cyc & req.stb & ~req.we & (req.adr == ofs);
  endfunction

  // Bus decode. Writes and read side effects act only in the idle cycle that takes
  // the request, one cycle before the ack, so a held request takes effect exactly once.
  wire       bus_take     = wb_req_i.cyc & wb_req_i.stb & (bus_state == kmw_pkg::KMW_BUS_IDLE);
  wire [7:0] wdat         = wb_req_i.dat[7:0];
  wire       wr_ctl       = bus_take & wr_hit(wb_req_i, `KMW_OFS_CTL);
  wire       wr_kbc_rst   = bus_take & wr_hit(wb_req_i, `KMW_OFS_KBC_RST);
  wire       wr_wake_sts  = bus_take & wr_hit(wb_req_i, `KMW_OFS_WAKE_STS);
  wire       wr_wake_en   = bus_take & wr_hit(wb_req_i, `KMW_OFS_WAKE_EN);
  wire       wr_int_mask  = bus_take & wr_hit(wb_req_i, `KMW_OFS_INT_MASK);
  wire       rd_int_sts   = bus_take & rd_hit(wb_req_i, `KMW_OFS_INT_STS);

  wire [7:0] rd_byte =
    (wb_req_i.adr == `KMW_OFS_CTL)       ? ctl_reg :
    (wb_req_i.adr == `KMW_OFS_KBC_RST)   ? kbc_rst_reg :
    (wb_req_i.adr == `KMW_OFS_WAKE_STS)  ? wake_sts :
    (wb_req_i.adr == `KMW_OFS_WAKE_EN)   ? wake_en :
    (wb_req_i.adr == `KMW_OFS_INT_STS)   ? int_sts :
    (wb_req_i.adr == `KMW_OFS_INT_MASK)  ? int_mask :
    `KMW_RST_BYTE;

  // Data-line edge detection. The pins feed the wake logic straight, with no
  // isolation in the path, so external devices always reach the status bits.
  logic kbd_data_fall;
  logic mouse_data_fall;

  kmw_fall_sync u_kbd_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .line_i    (kbd_line_i.data_line),
    .level_o   (),
    .fall_o    (kbd_data_fall)
  ); // see (RQ13)

  kmw_fall_sync u_mouse_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .line_i    (mouse_line_i.data_line),
    .level_o   (),
    .fall_o    (mouse_data_fall)
  ); // see (RQ13)

  // Interrupt selection between gated and latched forms.
  wire kiso        = ctl_reg[`KMW_BIT_KISO];
  wire miso        = ctl_reg[`KMW_BIT_MISO];
  wire next_kbd_irq   = ctl_reg[`KMW_BIT_KBD_LSEL] ? kbd_latch
                                                   : (kbd_irq_i & kbd_latch);     // see (RQ3)
  wire next_mouse_irq = ctl_reg[`KMW_BIT_MOUSE_LSEL] ? mouse_latch
                                                     : (mouse_irq_i & mouse_latch); // see (RQ2)

  // Interrupt-sourced wakes come from the internal controller, so they need
  // main power and are suppressed while that port is isolated.
  wire kbd_irq_rise   = next_kbd_irq & ~kbd_irq_src_d;
  wire mouse_irq_rise = next_mouse_irq & ~mouse_irq_src_d;
  wire kbd_irq_wake   = kbd_irq_rise & main_power_good_i & ~kiso;     // see (RQ6) see (RQ14)
  wire mouse_irq_wake = mouse_irq_rise & main_power_good_i & ~miso;   // see (RQ6) see (RQ14)
  wire kbd_wake_set   = kbd_irq_wake | kbd_data_fall;                 // see (RQ4)
  wire mouse_wake_set = mouse_irq_wake | mouse_data_fall;             // see (RQ4)

  wire [7:0] wake_set_vec = {3'h0, mouse_wake_set, kbd_wake_set, 3'h0};
  wire [7:0] wake_clr_vec = wr_wake_sts ? (wdat & `KMW_WAKE_MASK) : 8'h00;
  wire [7:0] next_wake_sts = (wake_sts & ~wake_clr_vec) | wake_set_vec;
  wire [7:0] next_int_sts  = (rd_int_sts ? 8'h00 : int_sts) | wake_set_vec;
  wire       next_wake_out = wake_en[`KMW_BIT_GLOBAL_EN] &
                             (|(wake_sts & wake_en & `KMW_WAKE_MASK)); // see (RQ5)

  // Isolated lines are presented to the controller as idle-high.
  wire kmw_pkg::kmw_ps2_t next_kbc_kbd;
  wire kmw_pkg::kmw_ps2_t next_kbc_mouse;
  assign next_kbc_kbd   = kiso ? 2'b11 : kbd_line_i;    // see (RQ8)
  assign next_kbc_mouse = miso ? 2'b11 : mouse_line_i;  // see (RQ7)

  // Standby-well state: only the standby power-on reset clears it.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ctl_reg  <= `KMW_RST_BYTE;
      wake_en  <= `KMW_RST_BYTE;
      wake_sts <= `KMW_RST_BYTE;
      int_sts  <= `KMW_RST_BYTE;
      int_mask <= `KMW_RST_BYTE;
    end
    else
    begin
      if (wr_ctl)
        ctl_reg <= wdat & `KMW_CTL_MASK;   // see (RQ1) see (RQ9)
      if (wr_wake_en)
        wake_en <= wdat & `KMW_EN_MASK;    // see (RQ15)
      if (wr_int_mask)
        int_mask <= wdat & `KMW_WAKE_MASK;
      wake_sts <= next_wake_sts;           // see (RQ4)
      int_sts  <= next_int_sts;
    end
  end

  // Main-well state: the main-power reset clears it as well, so a controller
  // held in reset comes back out of reset when main power returns.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i | main_reset_i)
      kbc_rst_reg <= `KMW_RST_BYTE;
    else if (wr_kbc_rst)
      kbc_rst_reg <= wdat;                 // see (RQ10)
  end

  // The latch catches a controller interrupt and holds it until the host
  // drains the controller; a new interrupt in the clear cycle wins.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i | main_reset_i)
    begin
      kbd_latch   <= 1'b0;
      mouse_latch <= 1'b0;
    end
    else
    begin
      kbd_latch   <= kbd_irq_i | (kbd_latch & ~kbd_irq_clr_i);
      mouse_latch <= mouse_irq_i | (mouse_latch & ~mouse_irq_clr_i);
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      kbd_irq_o        <= 1'b0;
      mouse_irq_o      <= 1'b0;
      kbd_irq_src_d    <= 1'b0;
      mouse_irq_src_d  <= 1'b0;
      kbc_reset_o      <= 1'b0;
      wake_event_out_o <= 1'b0;
      irq_o            <= 1'b0;
      kbc_kbd_line_o   <= 2'b11;
      kbc_mouse_line_o <= 2'b11;
    end
    else
    begin
      kbd_irq_o        <= next_kbd_irq;
      mouse_irq_o      <= next_mouse_irq;
      kbd_irq_src_d    <= next_kbd_irq;
      mouse_irq_src_d  <= next_mouse_irq;
      kbc_reset_o      <= kbc_rst_reg[`KMW_BIT_KBC_RST]; // see (RQ10)
      wake_event_out_o <= next_wake_out;
      irq_o            <= |(int_sts & int_mask);
      kbc_kbd_line_o   <= next_kbc_kbd;
      kbc_mouse_line_o <= next_kbc_mouse;
    end
  end

  // Bus slave: ack one cycle after the request, dropped the cycle after.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i | bus_reset_i)
    begin
      bus_state <= kmw_pkg::KMW_BUS_IDLE;
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
    end
    else
    begin
      case (bus_state)
        kmw_pkg::KMW_BUS_IDLE:
        begin
          wb_ack_o <= bus_take;
          wb_dat_o <= {24'h00_0000, rd_byte};
          if (bus_take)
            bus_state <= kmw_pkg::KMW_BUS_ACK;
        end
        kmw_pkg::KMW_BUS_ACK:
        begin
          wb_ack_o  <= 1'b0;
          bus_state <= kmw_pkg::KMW_BUS_IDLE;
        end
        default:
        begin
          wb_ack_o  <= 1'b0;
          bus_state <= kmw_pkg::KMW_BUS_IDLE;
        end
      endcase
    end
  end

  // Checks.
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  sequence s_kbd_iso_written;
    wr_ctl && wdat[`KMW_BIT_KISO];
  endsequence

  sequence s_kbd_line_blocked;
    kbc_kbd_line_o == 2'b11;
  endsequence

  property p_kbd_isolate;
    s_kbd_iso_written ##1 (!main_reset_i && !wr_ctl)[*1] |=> s_kbd_line_blocked;
  endproperty
  a_kbd_isolate: assert property (p_kbd_isolate) // see (RQ8)
    else $error("keyboard lines not blocked");

  property p_mouse_isolate;
    miso |=> kbc_mouse_line_o == 2'b11;
  endproperty
  a_mouse_isolate: assert property (p_mouse_isolate) // see (RQ7)
    else $error("mouse lines not blocked");

  property p_iso_keeps_main_reset;
    main_reset_i && !wr_ctl |=> $stable(ctl_reg);
  endproperty
  a_iso_keeps_main_reset: assert property (p_iso_keeps_main_reset) // see (RQ9)
    else $error("main reset changed isolation bits");

  property p_en_keeps_main_reset;
    (main_reset_i || bus_reset_i) && !wr_wake_en |=> $stable(wake_en);
  endproperty
  a_en_keeps_main_reset: assert property (p_en_keeps_main_reset) // see (RQ15)
    else $error("main reset changed wake enables");

  property p_kbd_irq_select;
    ##1 kbd_irq_o == ($past(ctl_reg[`KMW_BIT_KBD_LSEL]) ? $past(kbd_latch)
                                                        : ($past(kbd_irq_i) && $past(kbd_latch)));
  endproperty
  a_kbd_irq_select: assert property (p_kbd_irq_select) // see (RQ3)
    else $error("keyboard irq select wrong");

  property p_mouse_irq_latched;
    ctl_reg[`KMW_BIT_MOUSE_LSEL] && mouse_latch |=> mouse_irq_o;
  endproperty
  a_mouse_irq_latched: assert property (p_mouse_irq_latched) // see (RQ2)
    else $error("mouse irq not latched");

  property p_data_edge_sets;
    kbd_data_fall |=> wake_sts[`KMW_BIT_KBD_WAKE];
  endproperty
  a_data_edge_sets: assert property (p_data_edge_sets) // see (RQ13)
    else $error("data edge lost");

  property p_irq_wake_needs_power;
    $rose(wake_sts[`KMW_BIT_MOUSE_WAKE]) |-> $past(mouse_data_fall) ||
      ($past(main_power_good_i) && !$past(miso));
  endproperty
  a_irq_wake_needs_power: assert property (p_irq_wake_needs_power) // see (RQ6)
    else $error("mouse wake without cause");

  // An isolated or unpowered controller must not wake the system by itself.
  property p_kbd_irq_wake_blocked;
    !kbd_data_fall && (kiso || !main_power_good_i) && !wake_sts[`KMW_BIT_KBD_WAKE]
      |=> !wake_sts[`KMW_BIT_KBD_WAKE];
  endproperty
  a_kbd_irq_wake_blocked: assert property (p_kbd_irq_wake_blocked) // see (RQ14)
    else $error("blocked keyboard wake set");

  property p_mouse_irq_wake_blocked;
    !mouse_data_fall && (miso || !main_power_good_i) && !wake_sts[`KMW_BIT_MOUSE_WAKE]
      |=> !wake_sts[`KMW_BIT_MOUSE_WAKE];
  endproperty
  a_mouse_irq_wake_blocked: assert property (p_mouse_irq_wake_blocked) // see (RQ14)
    else $error("blocked mouse wake set");

  property p_wake_out;
    wake_sts[`KMW_BIT_KBD_WAKE] && wake_en[`KMW_BIT_KBD_WAKE] && wake_en[`KMW_BIT_GLOBAL_EN]
      |=> wake_event_out_o;
  endproperty
  a_wake_out: assert property (p_wake_out) // see (RQ5)
    else $error("wake output missing");

  property p_wake_out_gated;
    !wake_en[`KMW_BIT_GLOBAL_EN] |=> !wake_event_out_o;
  endproperty
  a_wake_out_gated: assert property (p_wake_out_gated) // see (RQ5)
    else $error("wake output ungated");

  property p_kbc_reset_hold;
    wr_kbc_rst && wdat == `KMW_KBC_RST_VALUE && !main_reset_i
      |=> ##1 kbc_reset_o [*2];
  endproperty
  a_kbc_reset_hold: assert property (p_kbc_reset_hold) // see (RQ10)
    else $error("controller reset not held");

  property p_bus_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_bus_ack_once: assert property (p_bus_ack_once) else $error("ack held too long");

endmodule

// File: tb/kmw_partner.sv
// Far-side model: external keyboard and mouse pins and the controller's interrupts.
// Assumes the bench commands each pull-down and interrupt just after a rising edge.
`timescale 1ns/1ps

module kmw_partner (
  input  wire logic         clk_sys_i,
  input  wire logic [3:0]   pull_low_i,
  input  wire logic [1:0]   irq_req_i,
  input  wire logic         kbc_reset_i,
  output kmw_pkg::kmw_ps2_t kbd_line_o,
  output kmw_pkg::kmw_ps2_t mouse_line_o,
  output logic              kbd_irq_o,
  output logic              mouse_irq_o
);
  // Open-drain lines with pull-ups, so a released line reads high.
  assign kbd_line_o   = ~pull_low_i[1:0];
  assign mouse_line_o = ~pull_low_i[3:2];

  // A controller held in reset raises no interrupt.
  always_ff @(posedge clk_sys_i)
  begin
    kbd_irq_o   <= irq_req_i[0] & ~kbc_reset_i;
    mouse_irq_o <= irq_req_i[1] & ~kbc_reset_i;
  end
endmodule

// File: tb/kmw_wake_iso_bench.sv
// Self-checking bench for the keyboard and mouse wake and isolation block.
// Assumes the far-side model and a 25 MHz system clock.
`timescale 1ns/1ps

module kmw_wake_iso_bench;
  logic                 clk_sys_i = 1'h0;
  logic                 rst_i = 1'h1;
  logic                 main_rst = 1'h0;
  logic                 bus_rst = 1'h0;
  logic                 pwr = 1'h1;
  kmw_pkg::kmw_wb_req_t wb_req = '0;
  logic [31:0]          wb_dat;
  logic                 wb_ack;
  kmw_pkg::kmw_ps2_t    kbd_ln;
  kmw_pkg::kmw_ps2_t    ms_ln;
  kmw_pkg::kmw_ps2_t    kbc_kbd;
  kmw_pkg::kmw_ps2_t    kbc_ms;
  logic [3:0]           pull_low = 4'h0;
  logic [1:0]           irq_req = 2'h0;
  logic [1:0]           irq_clr = 2'h0;
  logic                 p_kirq;
  logic                 p_mirq;
  logic                 kirq;
  logic                 mirq;
  logic                 kbc_rst;
  logic                 wake;
  logic                 irq;
  int                   failures = 0;
  int                   check_count = 0;

  always #20 clk_sys_i = ~clk_sys_i;

  kmw_partner kmw_partner_inst (.clk_sys_i(clk_sys_i), .pull_low_i(pull_low),
    .irq_req_i(irq_req), .kbc_reset_i(kbc_rst), .kbd_line_o(kbd_ln),
    .mouse_line_o(ms_ln), .kbd_irq_o(p_kirq), .mouse_irq_o(p_mirq));

  kmw_wake_iso kmw_wake_iso_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .main_reset_i(main_rst), .bus_reset_i(bus_rst), .main_power_good_i(pwr),
    .wb_req_i(wb_req), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .kbd_line_i(kbd_ln),
    .mouse_line_i(ms_ln), .kbc_kbd_line_o(kbc_kbd), .kbc_mouse_line_o(kbc_ms),
    .kbd_irq_i(p_kirq), .mouse_irq_i(p_mirq), .kbd_irq_clr_i(irq_clr[0]),
    .mouse_irq_clr_i(irq_clr[1]), .kbd_irq_o(kirq), .mouse_irq_o(mirq),
    .kbc_reset_o(kbc_rst), .wake_event_out_o(wake), .irq_o(irq));

  function automatic logic [1:0] exp_line(input logic iso, input logic [1:0] pull);
    return iso ? 2'h3 : ~pull;
  endfunction

  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask

  task automatic check_line(input kmw_pkg::kmw_ps2_t got, input logic [1:0] exp);
    check({30'h0, got}, {30'h0, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // The master assumes no fixed latency; only a long silence is treated as a hang.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    wb_req <= '{1'h1, 1'h1, we, 4'hF, a, d};
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (wb_ack !== 1'h1 && n < 20);
    rd = wb_dat;
    wb_req <= '0;
    if (n >= 20)
    begin
      failures++;
      $display("CHECK FAILED at %0t: no bus answer", $time);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb(1'h1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    wb(1'h0, a, 32'h0, x);
    check(x, e);
  endtask

  initial
  begin
    #(40 * 20000);
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial
  begin
    logic [7:0] r;
    logic [31:0] b;
    logic [7:0] ofs [7];
    int k;
    ofs = '{8'h10, 8'h14, 8'h18, 8'h1C, 8'hF0, 8'h2C, 8'h40};
    void'($urandom(32'hB52B));
    cyc(12);
    rst_i <= 1'h0;
    foreach (ofs[i])
      rd_chk(ofs[i], 32'h0);
    wr(8'h40, 32'hFF);
    rd_chk(8'h40, 32'h0);
    r = 8'($urandom);
    wr(8'hF0, {24'h0, r});
    rd_chk(8'hF0, {24'h0, r & 8'h78});
    // Isolation per port, with random pin levels behind it.
    for (k = 0; k < 4; k++)
    begin
      r = 8'($urandom);
      wr(8'hF0, {25'h0, k[1:0], 5'h0});
      pull_low <= r[3:0];
      cyc(3);
      check_line(kbc_kbd, exp_line(k[0], r[1:0]));
      check_line(kbc_ms, exp_line(k[1], r[3:2]));
    end
    pull_low <= 4'h0;
    cyc(4);
    wr(8'h10, 32'h18);
    wr(8'h1C, 32'h18);
    wb(1'h0, 8'h18, 32'h0, b);
    // Data-line wakes pass with both ports isolated and main power gone.
    wr(8'hF0, 32'h60);
    pwr <= 1'h0;
    for (k = 0; k < 2; k++)
    begin
      b = 32'h8 << k;
      wr(8'h14, 32'h18);
      pull_low <= k ? 4'h4 : 4'h1;
      cyc(6);
      check_bit(wake, 1'h0);
      check_bit(irq, 1'h1);
      rd_chk(8'h10, b);
      wr(8'h14, 32'h19);
      cyc(2);
      check_bit(wake, 1'h1);
      rd_chk(8'h18, b);
      cyc(2);
      check_bit(irq, 1'h0);
      rd_chk(8'h18, 32'h0);
      pull_low <= 4'h0;
      cyc(4);
      wr(8'h10, b);
      cyc(2);
      check_bit(wake, 1'h0);
      rd_chk(8'h10, 32'h0);
    end
    // Interrupt wakes: latch selection and main power gating. Enables are
    // cleared first, as software does before a main-power sleep.
    wr(8'h14, 32'h0);
    for (k = 0; k < 4; k++)
    begin
      b = 32'h8 << k[0];
      wr(8'hF0, k[1] ? b : 32'h0);
      pwr <= 1'h0;
      irq_req <= k[0] ? 2'h2 : 2'h1;
      cyc(3);
      irq_req <= 2'h0;
      cyc(4);
      rd_chk(8'h10, 32'h0);
      irq_clr <= 2'h3;
      cyc(2);
      irq_clr <= 2'h0;
      pwr <= 1'h1;
      irq_req <= k[0] ? 2'h2 : 2'h1;
      cyc(4);
      check_bit(k[0] ? mirq : kirq, 1'h1);
      irq_req <= 2'h0;
      cyc(4);
      check_bit(k[0] ? mirq : kirq, k[1]);
      rd_chk(8'h10, b);
      check_bit(wake, 1'h0);
      irq_clr <= 2'h3;
      cyc(2);
      irq_clr <= 2'h0;
      wr(8'h10, 32'h18);
      wb(1'h0, 8'h18, 32'h0, b);
    end
    // Controller reset and which resets reach which registers.
    wr(8'h2C, 32'h40);
    cyc(2);
    check_bit(kbc_rst, 1'h1);
    wr(8'h14, 32'h19);
    wr(8'hF0, 32'h60);
    main_rst <= 1'h1;
    bus_rst <= 1'h1;
    cyc(2);
    main_rst <= 1'h0;
    bus_rst <= 1'h0;
    rd_chk(8'hF0, 32'h60);
    rd_chk(8'h14, 32'h19);
    rd_chk(8'h2C, 32'h0);
    // Resume with a port still isolated: the controller gets a reset pulse.
    wr(8'h2C, 32'h40);
    wr(8'h2C, 32'h0);
    cyc(2);
    check_bit(kbc_rst, 1'h0);
    rst_i <= 1'h1;
    cyc(2);
    rst_i <= 1'h0;
    rd_chk(8'hF0, 32'h0);
    rd_chk(8'h14, 32'h0);
    end_of_test();
  end
endmodule
